// >>> include/mdlc_pkg.sv
package mdlc_pkg;
  // clock and time base
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  // times in minutes, seconds and milliseconds
  localparam int BLANK_MIN = 8;
  localparam int BLANK_MS = BLANK_MIN * 60 * 1000;
  localparam int TECH_S = 5;
  localparam int SETUP_S = 7;
  localparam int TEST_S = 9;
  localparam int TECH_MS = TECH_S * 1000;
  localparam int SETUP_MS = SETUP_S * 1000;
  localparam int TEST_MS = TEST_S * 1000;
  localparam int LONG_MS = 2000;
  localparam int OK_MS = 2000;
  localparam int BLINK_MS = 500;
  localparam int HEART_MS = 1000;
  // reading index space per loop
  localparam logic [7:0] LAST_PRIMARY = 8'h1F;
  localparam logic [3:0] LAST_SECONDARY = 4'hF;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INFO_OFS = 8'h08;
  localparam logic [7:0] SEG_OFS = 8'h0C;
  // control fields and reset value
  localparam int CTRL_DIGITS8_BIT = 0;
  localparam int CTRL_CC_BLOCK_BIT = 1;
  localparam int CTRL_TRANSPORT_BIT = 2;
  localparam int CTRL_SAVED_BIT = 3;
  localparam logic [2:0] CTRL_RESET = 3'h5;
  // status segment config: per segment {flash, on}
  localparam logic [5:0] SEG_RESET = 6'h00;
  localparam logic [5:0] INFO_RESET = 6'h00;
  // status field positions
  localparam int ST_LOOP_LSB = 0;
  localparam int ST_SEC_BIT = 2;
  localparam int ST_ON_BIT = 3;
  localparam int ST_LOCK_BIT = 4;
  localparam int ST_INDEX_LSB = 8;
  localparam int ST_SUB_LSB = 16;
  // info bits
  localparam int INFO_INLET_OPEN = 5;
  localparam int INFO_INLET_SHORT = 4;
  localparam int INFO_OUTLET_OPEN = 3;
  localparam int INFO_OUTLET_SHORT = 2;
  localparam int INFO_FLOW_FAIL = 1;
  localparam int INFO_FLOW_REV = 0;

  typedef enum logic [1:0] {
    MDLC_USER, MDLC_TECH, MDLC_SETUP, MDLC_TEST
  } mdlc_loop_t;

  typedef struct packed {
    logic inlet_open;
    logic inlet_short;
    logic outlet_open;
    logic outlet_short;
    logic flow_fail;
    logic flow_reverse;
  } mdlc_err_t;

  typedef struct packed {
    logic inlet_temperature;
    logic outlet_temperature;
    logic temp_difference;
    logic flow;
    logic power;
  } mdlc_dash_t;

  typedef struct packed {
    logic heat_energy_total;
    logic cooling_energy_total;
    logic volume_inlet_temp_product;
    logic volume_outlet_temp_product;
    logic flow_volume_total;
  } mdlc_halt_t;
endpackage

// >>> design/mdlc_top.sv
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module mdlc_top
  import mdlc_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // pins: front key and seal contacts, high = pressed / broken
  input wire logic key_in,
  input wire logic setup_seal_in,
  input wire logic test_seal_in,
  // measuring core
  input wire logic first_integration_in,
  input wire logic core_alive_in,
  input wire logic cooling_in,
  input wire mdlc_err_t err_in,
  // display
  output logic display_on_out,
  output logic digits8_out,
  output logic info_symbol_out,
  output logic ok_symbol_out,
  output logic heartbeat_out,
  output logic [2:0] status_seg_out,
  output mdlc_loop_t loop_out,
  output logic secondary_out,
  output logic index_visible_out,
  output logic [7:0] index_out,
  output logic [3:0] sub_index_out,
  output mdlc_dash_t dash_out,
  output logic energy_neg_out,
  output logic delta_neg_out,
  output logic power_neg_out,
  // accumulators
  output mdlc_halt_t halt_out
);

  function automatic logic ms_reached(input logic [19:0] c,
                                      input int lim);
    ms_reached = (c == 20'(lim - 1));
  endfunction

  logic [2:0] key_sync, seal_s_sync, seal_t_sync;
  logic key, key_prev, setup_seal, test_seal;
  logic [15:0] div_cnt;
  logic tick;
  logic [19:0] idle_ms, hold_ms, ok_ms, blink_ms, heart_ms;
  logic blink, heart;
  logic lock;
  logic [2:0] ctrl;
  logic [5:0] seg_cfg, info;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic ok_req;
  logic setup_allowed;
  logic press, release_ev;
  logic inlet_err, outlet_err, flow_err, any_err;
  logic [5:0] info_clr;
  mdlc_loop_t loop;

  // pins pass two flops; bit 0 feeds bit 1 only
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      key_sync <= 3'h0;
      seal_s_sync <= 3'h0;
      seal_t_sync <= 3'h0;
    end else begin
      key_sync <= {key_sync[1:0], key_in};
      seal_s_sync <= {seal_s_sync[1:0], setup_seal_in};
      seal_t_sync <= {seal_t_sync[1:0], test_seal_in};
    end
  end
  assign key = key_sync[1];
  assign key_prev = key_sync[2];
  assign setup_seal = seal_s_sync[1];
  assign test_seal = seal_t_sync[1];
  assign press = key & ~key_prev;
  assign release_ev = ~key & key_prev;

  // millisecond tick
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (div_cnt == 16'(TICK_DIV - 1)) begin
      div_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // display wake and inactivity blanking
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      display_on_out <= 1'b0;
      idle_ms <= 20'h00000;
    end else if (press) begin
      display_on_out <= 1'b1;
      idle_ms <= 20'h00000;
    end else if (display_on_out && tick) begin
      if (ms_reached(idle_ms, BLANK_MS)) begin
        display_on_out <= 1'b0;
        idle_ms <= 20'h00000;
      end else begin
        idle_ms <= idle_ms + 20'h00001;
      end
    end
  end

  // lock survives everything but reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lock <= 1'b0;
    end else if (first_integration_in) begin
      lock <= 1'b1;
    end
  end

  // setup access: transport state unless country blocks, else unlocked or seal
  assign setup_allowed = ctrl[CTRL_TRANSPORT_BIT] ?
    ~ctrl[CTRL_CC_BLOCK_BIT] :
    (~lock | setup_seal);

  // hold timer and loop selection
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hold_ms <= 20'h00000;
      loop <= MDLC_USER;
    end else if (!key) begin
      hold_ms <= 20'h00000;
    end else if (tick) begin
      if (hold_ms != 20'hFFFFF) begin
        hold_ms <= hold_ms + 20'h00001;
      end
      if (ms_reached(hold_ms, TECH_MS)) begin
        loop <= MDLC_TECH;
      end else if (ms_reached(hold_ms, SETUP_MS) && setup_allowed) begin
        loop <= MDLC_SETUP;
      end else if (ms_reached(hold_ms, TEST_MS) && test_seal) begin
        loop <= MDLC_TEST;
      end
    end
  end
  assign loop_out = loop;

  // navigation; a press that changed loop starts the loop afresh
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      index_out <= 8'h00;
      sub_index_out <= 4'h0;
      secondary_out <= 1'b0;
    end else if (key && tick && ms_reached(hold_ms, TECH_MS)) begin
      index_out <= 8'h00;
      sub_index_out <= 4'h0;
      secondary_out <= 1'b0;
    end else if (release_ev && display_on_out) begin
      if (hold_ms < 20'(LONG_MS)) begin
        if (secondary_out) begin
          sub_index_out <= (sub_index_out == LAST_SECONDARY) ?
            4'h0 : sub_index_out + 4'h1;
        end else begin
          index_out <= (index_out == LAST_PRIMARY) ?
            8'h00 : index_out + 8'h01;
        end
      end else if (hold_ms < 20'(TECH_MS) && loop != MDLC_USER) begin
        secondary_out <= ~secondary_out;
        sub_index_out <= 4'h0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      index_visible_out <= 1'b0;
    end else begin
      index_visible_out <= (loop != MDLC_USER);
    end
  end

  // blink and heartbeat time bases
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      blink_ms <= 20'h00000;
      heart_ms <= 20'h00000;
      blink <= 1'b0;
      heart <= 1'b0;
    end else if (tick) begin
      blink_ms <= ms_reached(blink_ms, BLINK_MS) ?
        20'h00000 : blink_ms + 20'h00001;
      heart_ms <= ms_reached(heart_ms, HEART_MS) ?
        20'h00000 : heart_ms + 20'h00001;
      if (ms_reached(blink_ms, BLINK_MS)) begin
        blink <= ~blink;
      end
      if (ms_reached(heart_ms, HEART_MS)) begin
        heart <= ~heart;
      end
    end
  end

  // symbols and segments, all but the digits flag dark while blank
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      digits8_out <= 1'b0;
      info_symbol_out <= 1'b0;
      heartbeat_out <= 1'b0;
      status_seg_out <= 3'h0;
    end else begin
      digits8_out <= ctrl[CTRL_DIGITS8_BIT];
      info_symbol_out <= display_on_out && (info != 6'h00) &&
        blink;
      // stops toggling if the core stalls
      heartbeat_out <= display_on_out && core_alive_in &&
        heart;
      for (int i = 0; i < 3; i++) begin
        status_seg_out[i] <= display_on_out && seg_cfg[2*i] &&
          (!seg_cfg[2*i+1] || blink);
      end
    end
  end

  // ok indication after a stored change
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ok_symbol_out <= 1'b0;
      ok_ms <= 20'h00000;
    end else if (ok_req) begin
      ok_symbol_out <= 1'b1;
      ok_ms <= 20'h00000;
    end else if (ok_symbol_out && tick) begin
      if (ms_reached(ok_ms, OK_MS)) begin
        ok_symbol_out <= 1'b0;
      end
      ok_ms <= ok_ms + 20'h00001;
    end
  end

  // sensor faults grouped by the readings they spoil
  assign inlet_err = err_in.inlet_open | err_in.inlet_short;
  assign outlet_err = err_in.outlet_open | err_in.outlet_short;
  // reverse flow still measures, so it never dashes
  assign flow_err = err_in.flow_fail;
  assign any_err = inlet_err | outlet_err | flow_err;

  // error handling: dashes, halts and signs
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dash_out <= '0;
      halt_out <= '0;
      energy_neg_out <= 1'b0;
      delta_neg_out <= 1'b0;
      power_neg_out <= 1'b0;
    end else begin
      dash_out.inlet_temperature <= inlet_err;
      dash_out.outlet_temperature <= outlet_err;
      dash_out.temp_difference <= inlet_err | outlet_err;
      dash_out.flow <= flow_err;
      dash_out.power <= any_err;
      halt_out.heat_energy_total <= any_err;
      halt_out.cooling_energy_total <= any_err;
      halt_out.volume_inlet_temp_product <= inlet_err | flow_err;
      halt_out.volume_outlet_temp_product <= outlet_err | flow_err;
      halt_out.flow_volume_total <= flow_err;
      energy_neg_out <= 1'b0;
      delta_neg_out <= cooling_in;
      power_neg_out <= cooling_in;
    end
  end

  // ahb-lite slave, zero wait states, always okay
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      wr_pend <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
      wr_addr <= haddr_in;
    end
  end

  // registers written in the data phase
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl <= CTRL_RESET;
      seg_cfg <= SEG_RESET;
      ok_req <= 1'b0;
    end else begin
      ok_req <= 1'b0;
      if (wr_pend && wr_addr == CTRL_OFS) begin
        ctrl <= hwdata_in[2:0];
        ok_req <= hwdata_in[CTRL_SAVED_BIT];
      end
      if (wr_pend && wr_addr == SEG_OFS) begin
        seg_cfg <= hwdata_in[5:0];
      end
    end
  end

  // info codes: set wins over write-one-to-clear
  assign info_clr = (wr_pend && wr_addr == INFO_OFS) ? hwdata_in[5:0] : 6'h00;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      info <= INFO_RESET;
    end else begin
      info <= (info & ~info_clr) | err_in;
    end
  end

  // read data captured in the address phase
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hrdata_out <= 32'h00000000;
    end else if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
      unique case (haddr_in)
        CTRL_OFS: hrdata_out <= {29'h0, ctrl};
        STATUS_OFS: begin
          hrdata_out <= 32'h00000000;
          hrdata_out[ST_LOOP_LSB +: 2] <= loop;
          hrdata_out[ST_SEC_BIT] <= secondary_out;
          hrdata_out[ST_ON_BIT] <= display_on_out;
          hrdata_out[ST_LOCK_BIT] <= lock;
          hrdata_out[ST_INDEX_LSB +: 8] <= index_out;
          hrdata_out[ST_SUB_LSB +: 4] <= sub_index_out;
        end
        INFO_OFS: hrdata_out <= {26'h0, info};
        SEG_OFS: hrdata_out <= {26'h0, seg_cfg};
        default: hrdata_out <= 32'h00000000;
      endcase
    end
  end

endmodule

// >>> test/mdlc_chk_sva.sv
`timescale 1ns/1ps
module mdlc_chk
  import mdlc_pkg::*;
#(
  parameter int TICK_DIV = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // watched inputs
  input wire logic key_in,
  input wire logic core_alive_in,
  input wire logic cooling_in,
  input wire mdlc_err_t err_in,
  // watched outputs
  input wire logic display_on_out,
  input wire logic info_symbol_out,
  input wire logic heartbeat_out,
  input wire logic [2:0] status_seg_out,
  input wire mdlc_loop_t loop_out,
  input wire logic index_visible_out,
  input wire mdlc_dash_t dash_out,
  input wire mdlc_halt_t halt_out,
  input wire logic energy_neg_out,
  input wire logic delta_neg_out,
  input wire logic power_neg_out
);
  // one tick of slack: the design's first millisecond tick can come one cycle after the press
  localparam longint BLANK_CYC = longint'(BLANK_MS) * TICK_DIV - TICK_DIV;
  // latest point: eight cycles of sync delay plus three whole ticks of margin
  localparam longint BLANK_DUE = BLANK_CYC + 3 * longint'(TICK_DIV) + 8;
  logic [39:0] idle_cnt;
  logic key_q;
  logic in_bad, out_bad, fl, any_bad;
  assign in_bad = err_in.inlet_open | err_in.inlet_short;
  assign out_bad = err_in.outlet_open | err_in.outlet_short;
  assign fl = err_in.flow_fail;
  assign any_bad = in_bad | out_bad | fl;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  always_ff @(posedge clk_in) begin
    key_q <= key_in;
  end
  always_ff @(posedge clk_in) begin
    if (srst_in || (key_in && !key_q)) begin
      idle_cnt <= 40'h0;
    end else if (idle_cnt != 40'hFFFFFFFFFF) begin
      idle_cnt <= idle_cnt + 40'h1;
    end
  end
  a_wake_display: assert property (
    $rose(key_in) && !display_on_out |-> ##[1:4] display_on_out)
    else $error("display did not wake on key press");
  a_blank_late: assert property (
    $fell(display_on_out) |-> idle_cnt >= BLANK_CYC)
    else $error("display blanked too early");
  a_blank_due: assert property (
    idle_cnt == BLANK_DUE |-> !display_on_out)
    else $error("display still on after idle timeout");
  a_dash_map: assert property (
    !$past(srst_in) |-> dash_out == $past({in_bad, out_bad, in_bad | out_bad,
      fl, any_bad}))
    else $error("dash pattern wrong");
  a_halt_map: assert property (
    !$past(srst_in) |-> halt_out == $past({any_bad, any_bad, in_bad | fl,
                                           out_bad | fl, fl}))
    else $error("accumulator halt pattern wrong");
  a_index_shown: assert property (
    index_visible_out == ($past(loop_out) != MDLC_USER))
    else $error("index visibility wrong");
  a_energy_pos: assert property (!energy_neg_out)
    else $error("energy shown negative");
  a_cool_sign: assert property (
    !$past(srst_in) |->
      {delta_neg_out, power_neg_out} == {2{$past(cooling_in)}})
    else $error("cooling sign wrong");
  a_info_dark: assert property (
    !display_on_out && !$past(display_on_out) |-> !info_symbol_out)
    else $error("info symbol lit on dark display");
  a_seg_dark: assert property (
    !display_on_out && !$past(display_on_out) |-> status_seg_out == 3'h0)
    else $error("status segment lit on dark display");
  a_heart_idle: assert property (
    !core_alive_in && !$past(core_alive_in) && !$past(core_alive_in, 2)
      |-> $stable(heartbeat_out))
    else $error("heartbeat moved with core stopped");
endmodule

bind mdlc_top mdlc_chk #(.TICK_DIV(TICK_DIV)) u_chk (
  .clk_in, .srst_in, .key_in, .core_alive_in, .cooling_in, .err_in,
  .display_on_out, .info_symbol_out, .heartbeat_out, .status_seg_out,
  .loop_out, .index_visible_out, .dash_out, .halt_out, .energy_neg_out,
  .delta_neg_out, .power_neg_out
);

// >>> test/mdlc_key_operator.sv
`timescale 1ns/1ps
module mdlc_key_operator (
  // clock
  input wire logic clk_in,
  // front key, high while pressed
  output logic key_out
);
  initial key_out = 1'h0;
  // rest after release so the synchroniser settles before the next act
  task automatic press(input int n);
    @(posedge clk_in);
    key_out <= 1'h1;
    repeat (n) @(posedge clk_in);
    key_out <= 1'h0;
    repeat (20) @(posedge clk_in);
  endtask
endmodule

// >>> test/meter_display_loop_control_bench.sv
`timescale 1ns/1ps
module meter_display_loop_control_bench;
  import mdlc_pkg::*;
  // one tick per cycle keeps the 9 s holds affordable
  localparam int TK = 1;
  localparam logic [4:0] DX [6] = '{5'h00, 5'h03, 5'h0D, 5'h0D, 5'h15, 5'h15};
  localparam logic [4:0] HX [6] = '{5'h00, 5'h1F, 5'h1A, 5'h1A, 5'h1C, 5'h1C};
  logic clk_in = 1'h0;
  logic srst_in = 1'h1;
  logic hsel = 1'h0, hwrite = 1'h0, fint = 1'h0, alive = 1'h1, cool = 1'h0;
  logic sseal = 1'h0, tseal = 1'h0, key;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  mdlc_err_t err = '0;
  logic hready, hresp, disp, dig8, info, ok, heart, sec, ivis, en, dn, pn;
  logic [2:0] seg;
  logic [7:0] idx;
  logic [3:0] sub;
  mdlc_loop_t loop;
  mdlc_dash_t dash;
  mdlc_halt_t halt;
  int mismatches = 0;
  int n_checks = 0;

  always #12.5 clk_in = ~clk_in;

  mdlc_key_operator u_op (.clk_in(clk_in), .key_out(key));

  mdlc_top #(.TICK_DIV(TK)) u_dut (
    .clk_in(clk_in), .srst_in(srst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .key_in(key),
    .setup_seal_in(sseal), .test_seal_in(tseal),
    .first_integration_in(fint), .core_alive_in(alive),
    .cooling_in(cool), .err_in(err), .display_on_out(disp),
    .digits8_out(dig8), .info_symbol_out(info), .ok_symbol_out(ok),
    .heartbeat_out(heart), .status_seg_out(seg), .loop_out(loop),
    .secondary_out(sec), .index_visible_out(ivis), .index_out(idx),
    .sub_index_out(sub), .dash_out(dash), .energy_neg_out(en),
    .delta_neg_out(dn), .power_neg_out(pn), .halt_out(halt)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk_in);
    while (hready !== 1'h1) @(posedge clk_in);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_in);
    while (hready !== 1'h1) @(posedge clk_in);
    q = hrdata;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk_in);
    mismatches++;
    test_done();
  end

  initial begin
    int ci, ch, cs;
    ci = 0;
    ch = 0;
    cs = 0;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'h0;
    // digits flag follows ctrl one cycle after reset ends
    repeat (2) @(posedge clk_in);
    chk(32'({disp, dig8, hready, hresp, loop}), 32'h18);
    bus(1'h0, CTRL_OFS, 32'h0);
    chk(q, 32'h5);
    bus(1'h0, 8'h10, 32'h0);
    chk(q, 32'h0);
    u_op.press(100 * TK);
    chk(32'({disp, ivis}), 32'h2);
    u_op.press(5500 * TK);
    chk(32'({loop, ivis}), 32'h3);
    u_op.press(100 * TK);
    bus(1'h0, STATUS_OFS, 32'h0);
    chk(32'({q[15:8], idx}), 32'h0101);
    u_op.press(3000 * TK);
    chk(32'(sec), 32'h1);
    u_op.press(7500 * TK);
    chk(32'(loop), 32'(MDLC_SETUP));
    bus(1'h1, CTRL_OFS, 32'h6);
    u_op.press(7500 * TK);
    chk(32'({loop, dig8}), 32'h2);
    bus(1'h1, CTRL_OFS, 32'h1);
    fint <= 1'h1;
    @(posedge clk_in);
    fint <= 1'h0;
    bus(1'h0, STATUS_OFS, 32'h0);
    chk(32'(q[4]), 32'h1);
    u_op.press(7500 * TK);
    chk(32'(loop), 32'(MDLC_TECH));
    sseal <= 1'h1;
    u_op.press(7500 * TK);
    chk(32'(loop), 32'(MDLC_SETUP));
    sseal <= 1'h0;
    u_op.press(9500 * TK);
    chk(32'(loop), 32'(MDLC_TECH));
    tseal <= 1'h1;
    u_op.press(9500 * TK);
    chk(32'(loop), 32'(MDLC_TEST));
    for (int i = 0; i < 6; i++) begin
      err <= mdlc_err_t'(6'h1 << i);
      repeat (3) @(posedge clk_in);
      chk(32'(dash), 32'(DX[i]));
      chk(32'(halt), 32'(HX[i]));
    end
    err <= '0;
    bus(1'h0, INFO_OFS, 32'h0);
    chk(q, 32'h3F);
    bus(1'h1, SEG_OFS, 32'h3);
    repeat (1100 * TK) begin
      @(posedge clk_in);
      ci += int'(info);
      ch += int'(heart);
      cs += int'(seg[0]);
    end
    chk(32'(ci > 0 && ci < 1100 * TK), 32'h1);
    chk(32'(ch > 0 && ch < 1100 * TK), 32'h1);
    chk(32'(cs > 0 && cs < 1100 * TK), 32'h1);
    alive <= 1'h0;
    repeat (3) @(posedge clk_in);
    ch = 0;
    repeat (1100 * TK) begin
      @(posedge clk_in);
      ch += int'(heart);
    end
    chk(32'(ch), 32'h0);
    alive <= 1'h1;
    bus(1'h1, INFO_OFS, 32'h3F);
    bus(1'h0, INFO_OFS, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, SEG_OFS, 32'h15);
    cool <= 1'h1;
    repeat (3) @(posedge clk_in);
    chk(32'(seg), 32'h7);
    chk(32'({en, dn, pn}), 32'h3);
    bus(1'h1, CTRL_OFS, 32'h9);
    repeat (4) @(posedge clk_in);
    chk(32'(ok), 32'h1);
    bus(1'h0, CTRL_OFS, 32'h0);
    chk(q, 32'h1);
    repeat (2100 * TK) @(posedge clk_in);
    chk(32'(ok), 32'h0);
    // last press is far inside the idle limit, so no blanking yet
    chk(32'(disp), 32'h1);
    test_done();
  end
endmodule
